// ---- include/uhr_regs.svh ----
// register offsets, field positions and reset values of the uart holding block
// assumes a 3-bit register address and an 8-bit host data bus
`ifndef UHR_REGS_SVH
`define UHR_REGS_SVH

`define UHR_OFF_HOLD    3'h0
`define UHR_OFF_IER     3'h1
`define UHR_OFF_ISR_FCR 3'h2
`define UHR_OFF_LCR     3'h3
`define UHR_OFF_LSR     3'h5

`define UHR_LCR_DLAB    7
`define UHR_IER_LOWPWR  5
`define UHR_IER_SLEEP   4
`define UHR_FCR_ENABLE  0
`define UHR_FCR_RXRST   1
`define UHR_FCR_TXRST   2
`define UHR_FCR_BIG     5

`define UHR_IER_RESET   8'h00
`define UHR_IER_USED    8'h3f
`define UHR_LCR_RESET   8'h00
`define UHR_LSR_RESET   8'h60

`define UHR_ISR_NONE    4'h1
`define UHR_ISR_RLS     4'h6
`define UHR_ISR_RDA     4'h4
`define UHR_ISR_THR     4'h2
`define UHR_ISR_MSR     4'h0

`define UHR_START_MID   4'h7
`define UHR_BIT_LAST    4'hf
`define UHR_DATA_LAST   3'h7

`endif

// ---- include/uhr_pkg.sv ----
// types shared by the uart holding block
// assumes nothing beyond a SystemVerilog tool
package uhr_pkg;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uhr_rx_e;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uhr_tx_e;
endpackage

// ---- logic/uhr_core.sv ----
// uart holding registers, interrupt enable, line status and serial framing (8N1)
// assumes the host bus strobes are synchronous to clk; rxPin is asynchronous
`include "uhr_regs.svh"

module uhr_core
   import uhr_pkg::*;
#(
   parameter int         TX_DEPTH = 64,
   parameter int         RX_DEPTH = 64,
   parameter logic [7:0] BAUD_DIV = 8'h04,
   parameter int         TRIG_L0  = 1,
   parameter int         TRIG_L1  = 4,
   parameter int         TRIG_L2  = 8,
   parameter int         TRIG_L3  = 14
)
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // host register bus
   input  wire logic       busCs,
   input  wire logic       busRd,
   input  wire logic       busWr,
   input  wire logic [2:0] busAddr,
   input  wire logic [7:0] busDataIn,
   output logic      [7:0] busDataOut,
   output logic            busDataOe,
   // serial line
   input  wire logic       rxPin,
   output logic            txPin,
   // modem status source and interrupt
   input  wire logic       modemIrq,
   output logic            irqOut,
   // power control
   output logic            sleepOn,
   output logic            coreClkOff
);
   localparam int TPW = $clog2(TX_DEPTH);
   localparam int RPW = $clog2(RX_DEPTH);
   localparam int TCW = TPW + 1;
   localparam int RCW = RPW + 1;

   if (TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0 ||
       RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0 ||
       TRIG_L3 > RX_DEPTH || TRIG_L0 < 1 || BAUD_DIV == 8'h00)
   begin : g_bad_params
      $error("uhr_core: depths must be powers of two and triggers fit the fifo");
   end

   typedef struct packed {
      logic [7:0]                  irq_enable_mask;
      logic [7:0]                  line_control_reg;
      logic                        fifoEn;
      logic                        fifoBig;
      logic [1:0]                  trig;
      logic [TX_DEPTH-1:0][7:0]    txMem;
      logic [TPW-1:0]              txWr;
      logic [TPW-1:0]              txRd;
      logic [TCW-1:0]              txCnt;
      logic [RX_DEPTH-1:0][9:0]    rxMem;
      logic [RPW-1:0]              rxWr;
      logic [RPW-1:0]              rxRd;
      logic [RCW-1:0]              rxCnt;
      logic [RCW-1:0]              rxErrCnt;
      logic [3:0]                  lsrErr;
      logic [2:0]                  rxSync;
      logic                        rxLine;
      uhr_rx_e                     rxSt;
      logic [3:0]                  rxTick;
      logic [2:0]                  rxBits;
      logic [7:0]                  rxShift;
      uhr_tx_e                     txSt;
      logic [3:0]                  txTick;
      logic [2:0]                  txBits;
      logic [7:0]                  txShift;
      logic                        txOut;
      logic [7:0]                  divCnt;
      logic                        tick;
      logic                        modemQ;
      logic                        sleep;
      logic [7:0]                  dOut;
      logic                        dOe;
   } uhr_state_s;

   uhr_state_s s_q;
   uhr_state_s s_d;

   logic           dlab;
   logic           wrHold;
   logic           rdHold;
   logic           wrIer;
   logic           wrFcr;
   logic           rdLsr;
   logic           txPop;
   logic           txAcc;
   logic           rxFall;
   logic           rxPush;
   logic           rxStore;
   logic           rxPop;
   logic [1:0]     rxErr;
   logic [TCW-1:0] txLim;
   logic [RCW-1:0] rxLim;
   logic [RCW-1:0] trigLvl;
   logic           pendRda;
   logic           pendThr;
   logic           pendRls;
   logic [7:0]     line_status_reg;
   logic [3:0]     isrCode;
   logic           wake;

   always_comb
   begin
      s_d     = s_q;
      dlab    = s_q.line_control_reg[`UHR_LCR_DLAB];
      // divisor latch set hides the holding and enable registers
      wrHold  = busCs & busWr & !dlab & (busAddr == `UHR_OFF_HOLD);
      rdHold  = busCs & busRd & !dlab & (busAddr == `UHR_OFF_HOLD);
      wrIer   = busCs & busWr & !dlab & (busAddr == `UHR_OFF_IER);
      wrFcr   = busCs & busWr & (busAddr == `UHR_OFF_ISR_FCR);
      rdLsr   = busCs & busRd & (busAddr == `UHR_OFF_LSR);
      txLim   = s_q.fifoEn ? TCW'(TX_DEPTH) : TCW'(1);
      rxLim   = s_q.fifoEn ? RCW'(RX_DEPTH) : RCW'(1);
      unique case (s_q.trig)
         2'h0: trigLvl = RCW'(TRIG_L0);
         2'h1: trigLvl = RCW'(TRIG_L1);
         2'h2: trigLvl = RCW'(TRIG_L2);
         2'h3: trigLvl = RCW'(TRIG_L3);
      endcase

      // 16x sampling enable
      s_d.tick   = (s_q.divCnt == BAUD_DIV - 8'h01);
      s_d.divCnt = s_d.tick ? 8'h00 : s_q.divCnt + 8'h01;

      // rx line: third stage agreeing with second commits a change
      s_d.rxSync = {s_q.rxSync[1:0], rxPin};
      if (s_q.rxSync[1] == s_q.rxSync[2])
      begin
         s_d.rxLine = s_q.rxSync[2];
      end
      rxFall = s_q.rxLine & (s_q.rxSync[2:1] == 2'b00);

      // transmit side: shifter pulls the oldest held byte when idle
      txPop = (s_q.txSt == TX_IDLE) && (s_q.txCnt != '0);
      txAcc = wrHold && ((s_q.txCnt < txLim) || txPop);
      if (txPop)
      begin
         s_d.txShift = s_q.txMem[s_q.txRd];
         s_d.txRd    = s_q.txRd + TPW'(1);
         s_d.txSt    = TX_START;
         s_d.txTick  = 4'h0;
      end
      else if (s_q.tick && s_q.txSt != TX_IDLE)
      begin
         s_d.txTick = s_q.txTick + 4'h1;
         if (s_q.txTick == `UHR_BIT_LAST)
         begin
            unique case (s_q.txSt)
               TX_START: s_d.txSt = TX_DATA;
               TX_DATA:
               begin
                  s_d.txShift = {1'b0, s_q.txShift[7:1]};
                  s_d.txBits  = s_q.txBits + 3'h1;
                  if (s_q.txBits == `UHR_DATA_LAST)
                  begin
                     s_d.txSt = TX_STOP;
                  end
               end
               TX_STOP:  s_d.txSt = TX_IDLE;
               TX_IDLE:  s_d.txSt = TX_IDLE;
            endcase
         end
      end
      if (txAcc)
      begin
         s_d.txMem[s_q.txWr] = busDataIn;
         s_d.txWr            = s_q.txWr + TPW'(1);
      end
      s_d.txCnt = s_q.txCnt + TCW'(txAcc) - TCW'(txPop);
      s_d.txOut = (s_d.txSt == TX_START) ? 1'b0 :
                  (s_d.txSt == TX_DATA) ? s_d.txShift[0] : 1'b1;

      // receive framing
      rxPush = 1'b0;
      rxErr  = 2'b00;
      unique case (s_q.rxSt)
         RX_IDLE:
            if (rxFall)
            begin
               s_d.rxSt   = RX_START;
               s_d.rxTick = 4'h0;
            end
         RX_START:
            if (s_q.tick)
            begin
               s_d.rxTick = s_q.rxTick + 4'h1;
               if (s_q.rxTick == `UHR_START_MID)
               begin
                  // glitch shorter than half a bit never assembles a character
                  s_d.rxSt   = s_q.rxLine ? RX_IDLE : RX_DATA;
                  s_d.rxTick = 4'h0;
                  s_d.rxBits = 3'h0;
               end
            end
         RX_DATA:
            if (s_q.tick)
            begin
               s_d.rxTick = s_q.rxTick + 4'h1;
               if (s_q.rxTick == `UHR_BIT_LAST)
               begin
                  s_d.rxShift = {s_q.rxLine, s_q.rxShift[7:1]};
                  s_d.rxBits  = s_q.rxBits + 3'h1;
                  if (s_q.rxBits == `UHR_DATA_LAST)
                  begin
                     s_d.rxSt = RX_STOP;
                  end
               end
            end
         RX_STOP:
            if (s_q.tick)
            begin
               s_d.rxTick = s_q.rxTick + 4'h1;
               if (s_q.rxTick == `UHR_BIT_LAST)
               begin
                  rxPush   = 1'b1;
                  rxErr    = {!s_q.rxLine && s_q.rxShift == 8'h00, !s_q.rxLine};
                  s_d.rxSt = RX_IDLE;
               end
            end
      endcase

      // receive fifo; overflow drops the new byte and flags overrun
      rxPop   = rdHold && (s_q.rxCnt != '0);
      rxStore = rxPush && ((s_q.rxCnt < rxLim) || rxPop);
      if (rxStore)
      begin
         s_d.rxMem[s_q.rxWr] = {rxErr, s_q.rxShift};
         s_d.rxWr            = s_q.rxWr + RPW'(1);
      end
      if (rxPop)
      begin
         s_d.rxRd = s_q.rxRd + RPW'(1);
      end
      s_d.rxCnt    = s_q.rxCnt + RCW'(rxStore) - RCW'(rxPop);
      s_d.rxErrCnt = s_q.rxErrCnt + RCW'(rxStore && rxErr != 2'b00)
                     - RCW'(rxPop && s_q.rxMem[s_q.rxRd][9:8] != 2'b00);
      // sticky errors; a new error in the read cycle survives the clear
      s_d.lsrErr = (rdLsr ? 4'h0 : s_q.lsrErr)
                   | {rxErr[1], rxErr[0], 1'b0, rxPush && !rxStore};

      // fifo control write; resets win over traffic in the same cycle
      if (wrFcr)
      begin
         s_d.fifoEn  = busDataIn[`UHR_FCR_ENABLE];
         s_d.fifoBig = busDataIn[`UHR_FCR_BIG];
         s_d.trig    = busDataIn[7:6];
         if (busDataIn[`UHR_FCR_RXRST])
         begin
            s_d.rxWr     = '0;
            s_d.rxRd     = '0;
            s_d.rxCnt    = '0;
            s_d.rxErrCnt = '0;
         end
         if (busDataIn[`UHR_FCR_TXRST])
         begin
            s_d.txWr  = '0;
            s_d.txRd  = '0;
            s_d.txCnt = '0;
         end
      end
      if (wrIer)
      begin
         s_d.irq_enable_mask = busDataIn & `UHR_IER_USED;
      end
      if (busCs && busWr && busAddr == `UHR_OFF_LCR)
      begin
         s_d.line_control_reg = busDataIn;
      end

      // status and pending sources
      pendThr = s_q.fifoEn ? (s_q.txCnt != txLim) : (s_q.txCnt == '0);
      pendRda = s_q.fifoEn ? (s_q.rxCnt >= trigLvl) : (s_q.rxCnt != '0);
      pendRls = (s_q.rxCnt != '0) || (s_q.lsrErr != 4'h0);
      line_status_reg = {s_q.fifoEn && s_q.rxErrCnt != '0,
             s_q.txCnt == '0 && s_q.txSt == TX_IDLE,
             pendThr, s_q.lsrErr, s_q.rxCnt != '0};
      if (pendRls && s_q.irq_enable_mask[2])
      begin
         isrCode = `UHR_ISR_RLS;
      end
      else if (pendRda && s_q.irq_enable_mask[0])
      begin
         isrCode = `UHR_ISR_RDA;
      end
      else if (pendThr && s_q.irq_enable_mask[1])
      begin
         isrCode = `UHR_ISR_THR;
      end
      else if (s_q.modemQ && s_q.irq_enable_mask[3])
      begin
         isrCode = `UHR_ISR_MSR;
      end
      else
      begin
         isrCode = `UHR_ISR_NONE;
      end

      // sleep and low power share one wake path
      s_d.modemQ = modemIrq;
      wake = (s_d.rxLine != s_q.rxLine) || rxFall || (modemIrq != s_q.modemQ)
             || wrHold;
      // pending mask rebuilt here; irqOut hangs off this process
      s_d.sleep = (s_q.irq_enable_mask[`UHR_IER_SLEEP] || s_q.irq_enable_mask[`UHR_IER_LOWPWR])
                  && !wake && !(|(s_q.irq_enable_mask[3:0] & {s_q.modemQ, pendRls, pendThr, pendRda}))
                  && s_q.txCnt == '0 && s_q.txSt == TX_IDLE
                  && s_q.rxSt == RX_IDLE && s_q.rxCnt == '0;

      // read data is registered, so it appears the cycle after the strobe
      s_d.dOe = busCs & busRd;
      if (busCs && busRd)
      begin
         unique case (busAddr)
            `UHR_OFF_HOLD:    s_d.dOut = dlab ? 8'h00 : s_q.rxMem[s_q.rxRd][7:0];
            `UHR_OFF_IER:     s_d.dOut = dlab ? 8'h00 : s_q.irq_enable_mask;
            `UHR_OFF_ISR_FCR: s_d.dOut = {s_q.fifoEn, s_q.fifoEn, s_q.fifoBig, 1'b0,
                                          isrCode};
            `UHR_OFF_LCR:     s_d.dOut = s_q.line_control_reg;
            `UHR_OFF_LSR:     s_d.dOut = line_status_reg;
            default:          s_d.dOut = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q        <= '0;
         s_q.irq_enable_mask    <= `UHR_IER_RESET;
         s_q.line_control_reg    <= `UHR_LCR_RESET;
         s_q.rxSync <= 3'h7;
         s_q.rxLine <= 1'b1;
         s_q.txOut  <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // polled mode is simply all four enables clear
   assign irqOut     = |(s_q.irq_enable_mask[3:0] & {s_q.modemQ, pendRls, pendThr, pendRda});
   assign sleepOn    = s_q.sleep & s_q.irq_enable_mask[`UHR_IER_SLEEP];
   assign coreClkOff = s_q.sleep & s_q.irq_enable_mask[`UHR_IER_LOWPWR];
   assign txPin      = s_q.txOut;
   assign busDataOut = s_q.dOut;
   assign busDataOe  = s_q.dOe;

   sequence falseStart;
      s_q.rxSt == RX_START && s_q.rxTick == `UHR_START_MID && s_q.tick && s_q.rxLine;
   endsequence
   sequence emptyIdle;
      s_q.txCnt == '0 && s_q.txSt == TX_IDLE;
   endsequence

   thr_accept_a: assert property (@(posedge clk) disable iff (!nrst)
      wrHold && !wrFcr && s_q.txCnt == '0 |=> s_q.txCnt == TCW'(1))
      else $error("holding write into empty transmitter not taken");
   thre_flag_a: assert property (@(posedge clk) disable iff (!nrst)
      s_q.fifoEn && s_q.txCnt == TCW'(TX_DEPTH) |-> !line_status_reg[5])
      else $error("holding empty flag set with full transmit fifo");
   rhr_pop_a: assert property (@(posedge clk) disable iff (!nrst)
      rdHold && s_q.rxCnt != '0 && !rxPush && !wrFcr |=> s_q.rxCnt == $past(s_q.rxCnt) - 1)
      else $error("holding read did not remove a byte");
   false_start_a: assert property (@(posedge clk) disable iff (!nrst)
      falseStart |=> s_q.rxSt == RX_IDLE ##1 s_q.rxSt != RX_DATA)
      else $error("false start not discarded");
   ier_unused_a: assert property (@(posedge clk) disable iff (!nrst)
      s_q.irq_enable_mask[7:6] == 2'b00)
      else $error("unused enable bits set");
   ier_apply_a: assert property (@(posedge clk) disable iff (!nrst)
      wrIer |=> s_q.irq_enable_mask == ($past(busDataIn) & `UHR_IER_USED))
      else $error("enable write not applied next cycle");
   polled_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
      s_q.irq_enable_mask[3:0] == 4'h0 |-> !irqOut)
      else $error("interrupt with all sources masked");
   rx_trigger_a: assert property (@(posedge clk) disable iff (!nrst)
      s_q.fifoEn && s_q.irq_enable_mask[0] && s_q.rxCnt >= trigLvl |-> irqOut && isrCode != `UHR_ISR_NONE)
      else $error("trigger level reached without interrupt");
   data_ready_a: assert property (@(posedge clk) disable iff (!nrst)
      rxStore && !wrFcr |=> line_status_reg[0] ##1 (line_status_reg[0] || $past(rdHold || wrFcr)))
      else $error("data ready not set after a received byte");
   temt_a: assert property (@(posedge clk) disable iff (!nrst)
      line_status_reg[6] |-> emptyIdle ##0 txPin)
      else $error("transmitter empty flag with data still queued");
   dlab_block_a: assert property (@(posedge clk) disable iff (!nrst)
      dlab && busCs && busWr && busAddr == `UHR_OFF_HOLD && s_q.txCnt == '0 |=> s_q.txCnt == '0)
      else $error("holding write taken with divisor latch set");
   no_sleep_pend_a: assert property (@(posedge clk) disable iff (!nrst)
      irqOut |=> !s_q.sleep)
      else $error("sleep entered with interrupt pending");
endmodule // uhr_core

// ---- testbench/uhr_line_model.sv ----
// serial line partner: sends 8N1 frames on rxPin, captures frames from txPin
// assumes BD clocks per 16x tick and 16 ticks per bit, as the uut is built
module uhr_line_model #(
   parameter int BD = 4
)
(
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // serial pins
   input  wire logic txPin,
   output logic      rxPin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got [$];
   logic [7:0] sh;
   initial rxPin = 1'b1;
   task automatic tick(input int n);
      repeat (n * BD) @(posedge clk);
   endtask
   // lsb first; stop level is a knob so a framing fault can be made on purpose
   task automatic send(input logic [7:0] d, input logic stopBit);
      @(posedge clk);
      #1 rxPin = 1'b0;
      tick(16);
      for (int i = 0; i < 8; i++)
      begin
         #1 rxPin = d[i];
         tick(16);
      end
      #1 rxPin = stopBit;
      tick(16);
      #1 rxPin = 1'b1;
      tick(16);
   endtask
   // low glitch well short of half a bit
   task automatic falseStart(input int n);
      @(posedge clk);
      #1 rxPin = 1'b0;
      tick(n);
      #1 rxPin = 1'b1;
   endtask
   // samples at bit centres, so a skewed bit clock shows up as wrong data
   initial
   begin
      forever
      begin
         @(posedge clk);
         if (nrst === 1'b1 && txPin === 1'b0)
         begin
            tick(8);
            for (int i = 0; i < 8; i++)
            begin
               tick(16);
               sh[i] = txPin;
            end
            tick(16);
            got.push_back(sh);
         end
      end
   end
endmodule // uhr_line_model

// ---- testbench/testbench.sv ----
// self-checking bench for uhr_core: host register tasks plus a serial partner
// assumes uhr_line_model on the pins; small fifo depths keep the run short
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BD = 4;
   logic       clk, nrst, busCs, busRd, busWr, modemIrq;
   logic       rxPin, txPin, busDataOe, irqOut, sleepOn, coreClkOff;
   logic [2:0] busAddr;
   logic [7:0] busDataIn, busDataOut;
   int         miscompares, n_checks;
   always #50 clk = ~clk;
   uhr_core #(
      .TX_DEPTH(4),
      .RX_DEPTH(4),
      .BAUD_DIV(8'h04)
   ) uut (
      .clk(clk), .nrst(nrst), .busCs(busCs), .busRd(busRd), .busWr(busWr),
      .busAddr(busAddr), .busDataIn(busDataIn), .busDataOut(busDataOut),
      .busDataOe(busDataOe), .rxPin(rxPin), .txPin(txPin), .modemIrq(modemIrq),
      .irqOut(irqOut), .sleepOn(sleepOn), .coreClkOff(coreClkOff)
   );
   uhr_line_model #(
      .BD(BD)
   ) line (
      .clk(clk), .nrst(nrst), .txPin(txPin), .rxPin(rxPin)
   );
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask
   task automatic pin(input logic v, input logic e);
      chk({7'h00, v}, {7'h00, e});
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 busCs = 1'b1;
      busWr = 1'b1;
      busAddr = a;
      busDataIn = d;
      @(posedge clk);
      #1 busCs = 1'b0;
      busWr = 1'b0;
      busDataIn = ~d;
   endtask
   // read data and enable are looked at in the single cycle they stand
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      #1 busCs = 1'b1;
      busRd = 1'b1;
      busAddr = a;
      @(posedge clk);
      #1 busCs = 1'b0;
      busRd = 1'b0;
      chk({7'h00, busDataOe}, 8'h01);
      chk(busDataOut, exp);
   endtask
   task automatic waitGot(input int n);
      for (int i = 0; i < 20000 && line.got.size() < n; i++)
         @(posedge clk);
      if (line.got.size() < n)
      begin
         $display("ERROR %0t: no frame seen on txPin", $time);
         miscompares++;
         results();
      end
      #1;
   endtask
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask
   initial
   begin
      clk = 1'b0;
      nrst = 1'b0;
      {busCs, busRd, busWr, modemIrq} = 4'h0;
      busAddr = 3'h0;
      busDataIn = 8'h00;
      miscompares = 0;
      n_checks = 0;
      repeat (20) @(posedge clk);
      #1 nrst = 1'b1;
      pin(irqOut, 1'b0);
      pin(sleepOn, 1'b0);
      pin(coreClkOff, 1'b0);
      rdc(3'h1, 8'h00);
      rdc(3'h5, 8'h60);
      rdc(3'h2, 8'h01);
      wr(3'h1, 8'hff);
      rdc(3'h1, 8'h3f);
      done("reset");
      wr(3'h1, 8'h02);
      pin(irqOut, 1'b1);
      rdc(3'h2, 8'h02);
      wr(3'h1, 8'h08);
      pin(irqOut, 1'b0);
      modemIrq = 1'b1;
      cyc(3);
      pin(irqOut, 1'b1);
      rdc(3'h2, 8'h00);
      modemIrq = 1'b0;
      cyc(3);
      pin(irqOut, 1'b0);
      done("mask");
      // divisor latch bit set: enable write must be lost
      wr(3'h3, 8'h80);
      wr(3'h1, 8'h0f);
      wr(3'h0, 8'h99);
      rdc(3'h1, 8'h00);
      wr(3'h3, 8'h00);
      rdc(3'h1, 8'h08);
      rdc(3'h5, 8'h60);
      done("latch");
      wr(3'h1, 8'h10);
      cyc(8);
      pin(sleepOn, 1'b1);
      wr(3'h0, 8'h5a);
      cyc(2);
      pin(sleepOn, 1'b0);
      rdc(3'h5, 8'h20);
      waitGot(1);
      chk(line.got.pop_front(), 8'h5a);
      cyc(40);
      rdc(3'h5, 8'h60);
      pin(sleepOn, 1'b1);
      wr(3'h1, 8'h20);
      cyc(8);
      pin(coreClkOff, 1'b1);
      wr(3'h1, 8'h00);
      done("tx");
      line.falseStart(3);
      cyc(700);
      rdc(3'h5, 8'h60);
      line.send(8'h3c, 1'b1);
      rdc(3'h5, 8'h61);
      wr(3'h1, 8'h04);
      pin(irqOut, 1'b1);
      rdc(3'h2, 8'h06);
      rdc(3'h0, 8'h3c);
      rdc(3'h5, 8'h60);
      pin(irqOut, 1'b0);
      done("rx");
      // fifo on, trigger select 01; one shifter plus four slots, sixth refused
      wr(3'h2, 8'h41);
      wr(3'h1, 8'h00);
      rdc(3'h2, 8'hc1);
      for (int i = 1; i < 7; i++)
         wr(3'h0, 8'(8'h11 * i));
      rdc(3'h5, 8'h00);
      waitGot(5);
      for (int i = 1; i < 6; i++)
         chk(line.got.pop_front(), 8'(8'h11 * i));
      cyc(40);
      rdc(3'h5, 8'h60);
      for (int i = 0; i < 4; i++)
         line.send(8'(8'h30 + i), 1'b1);
      pin(irqOut, 1'b0);
      rdc(3'h5, 8'h61);
      wr(3'h1, 8'h01);
      pin(irqOut, 1'b1);
      rdc(3'h2, 8'hc4);
      rdc(3'h0, 8'h30);
      pin(irqOut, 1'b0);
      rdc(3'h2, 8'hc1);
      for (int i = 1; i < 4; i++)
         rdc(3'h0, 8'(8'h30 + i));
      rdc(3'h5, 8'h60);
      done("fifo");
      line.send(8'h00, 1'b0);
      rdc(3'h5, 8'hf9);
      rdc(3'h5, 8'he1);
      rdc(3'h0, 8'h00);
      rdc(3'h5, 8'h60);
      done("error");
      // fifo resets drop queued bytes; the shifter still finishes its byte
      wr(3'h0, 8'h77);
      wr(3'h0, 8'h88);
      wr(3'h0, 8'h99);
      wr(3'h2, 8'h25);
      rdc(3'h5, 8'h20);
      waitGot(1);
      chk(line.got.pop_front(), 8'h77);
      cyc(700);
      chk(8'(line.got.size()), 8'h00);
      rdc(3'h5, 8'h60);
      line.send(8'h42, 1'b1);
      pin(irqOut, 1'b1);
      wr(3'h2, 8'h27);
      pin(irqOut, 1'b0);
      rdc(3'h5, 8'h60);
      rdc(3'h2, 8'he1);
      done("flush");
      results();
   end
endmodule // testbench
